// *** src/pllcc_top.sv ***
// clock path configuration registers and pattern-check event flags
//
// Function
// - sustained check mismatch sets flag bit 3; eight valid pairs clear it
// - sample check mismatch sets flag bit 2; held until software clears it
// - writing one to a flag bit clears it unless a mismatch sets it in the same cycle; zero bits leave it unchanged
// - register 0x08 bits 7/6: duty correction enables, reset zero
// - register 0x08 bits 5/4: crossing correction enables, reset one
// - register 0x0A bit 7 enables the PLL from the reference clock, reset zero
// - bit 6 set selects manual oscillator band from bits 5:0, software picks it
// - register 0x0C bits 7:6 loop bandwidth, 00 widest, reset 11
// - register 0x0C bits 4:0 charge pump current, reset 10001
// - register 0x0D bits 7:6 controller divider 2/4/8/16, reset 11
// - register 0x0D bit 4 enables cross-point controller, reset one
// - register 0x0D bits 3:2 oscillator divider, 00 gives 1, 01 gives 2
// - oscillator divider codes 10 and 11 both give 4
// - register 0x0D bits 1:0 loop divider 2/4/8/16, reset 01
`timescale 1ns/1ps
`include "pllcc_map.svh"

module pllcc_top
  import pllcc_pkg::*;
#(
  parameter int ADDR_W = `PLLCC_ADDR_W,
  parameter int DATA_W = `PLLCC_DATA_W,
  parameter int CLR_PAIRS = `PLLCC_AUTO_CLR_PAIRS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sustained_mismatch,
  input wire logic sample_mismatch,
  input wire logic valid_pair,
  output logic sustained_fail_flag,
  output logic sample_fail_flag,
  output logic conv_duty_corr_en,
  output logic ref_duty_corr_en,
  output logic conv_cross_corr_en,
  output logic ref_cross_corr_en,
  output logic pll_en,
  output logic manual_band_en,
  output logic [5:0] manual_oscillator_band,
  output logic [1:0] loop_bandwidth,
  output logic [4:0] charge_pump_current,
  output logic [1:0] controller_clock_divider,
  output logic cross_ctl_en,
  output logic [1:0] oscillator_output_divider,
  output logic [1:0] loop_divider,
  output logic [4:0] controller_clock_ratio,
  output logic [4:0] oscillator_output_ratio,
  output logic [4:0] loop_ratio
);

  if (ADDR_W < 8 || DATA_W != 8) begin : g_chk
    $error("pllcc_top: need ADDR_W >= 8 and DATA_W == 8");
  end

  // offset match helper, shared by read and write decode
  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [7:0] ofs
  );
    return a == ADDR_W'(ofs);
  endfunction : hit

  logic wr_flags;
  logic wr_rxctl;
  logic wr_pllen;
  logic wr_loopf;
  logic wr_divct;

  always_comb begin
    wr_flags = reg_wr && hit(reg_addr, `PLLCC_OFS_FLAGS);
    wr_rxctl = reg_wr && hit(reg_addr, `PLLCC_OFS_RXCTL);
    wr_pllen = reg_wr && hit(reg_addr, `PLLCC_OFS_PLLEN);
    wr_loopf = reg_wr && hit(reg_addr, `PLLCC_OFS_LOOPF);
    wr_divct = reg_wr && hit(reg_addr, `PLLCC_OFS_DIVCT);
  end

  // clock receiver control
  logic conv_duty_r, conv_duty_nxt;
  logic ref_duty_r, ref_duty_nxt;
  logic conv_cross_r, conv_cross_nxt;
  logic ref_cross_r, ref_cross_nxt;

  always_comb begin
    conv_duty_nxt = conv_duty_r;
    ref_duty_nxt = ref_duty_r;
    conv_cross_nxt = conv_cross_r;
    ref_cross_nxt = ref_cross_r;
    if (wr_rxctl) begin
      conv_duty_nxt = reg_wdata[`PLLCC_BIT_CONV_DUTY];
      ref_duty_nxt = reg_wdata[`PLLCC_BIT_REF_DUTY];
      conv_cross_nxt = reg_wdata[`PLLCC_BIT_CONV_CROSS];
      ref_cross_nxt = reg_wdata[`PLLCC_BIT_REF_CROSS];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv_duty_r <= `PLLCC_RST_CONV_DUTY;
      ref_duty_r <= `PLLCC_RST_REF_DUTY;
      conv_cross_r <= `PLLCC_RST_CONV_CROSS;
      ref_cross_r <= `PLLCC_RST_REF_CROSS;
    end else begin
      conv_duty_r <= conv_duty_nxt;
      ref_duty_r <= ref_duty_nxt;
      conv_cross_r <= conv_cross_nxt;
      ref_cross_r <= ref_cross_nxt;
    end
  end

  // PLL enable and manual band
  logic pll_en_r, pll_en_nxt;
  logic man_en_r, man_en_nxt;
  logic [5:0] band_r, band_nxt;

  always_comb begin
    pll_en_nxt = pll_en_r;
    man_en_nxt = man_en_r;
    band_nxt = band_r;
    if (wr_pllen) begin
      pll_en_nxt = reg_wdata[`PLLCC_BIT_PLL_EN];
      man_en_nxt = reg_wdata[`PLLCC_BIT_MAN_EN];
      band_nxt = reg_wdata[`PLLCC_BAND_HI:`PLLCC_BAND_LO];
    end
  end

  // band is not checked: software owns picking a band that locks
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pll_en_r <= `PLLCC_RST_PLL_EN;
      man_en_r <= `PLLCC_RST_MAN_EN;
      band_r <= `PLLCC_RST_BAND;
    end else begin
      pll_en_r <= pll_en_nxt;
      man_en_r <= man_en_nxt;
      band_r <= band_nxt;
    end
  end

  // loop filter and charge pump
  logic [1:0] bw_r, bw_nxt;
  logic [4:0] cp_r, cp_nxt;

  always_comb begin
    bw_nxt = bw_r;
    cp_nxt = cp_r;
    if (wr_loopf) begin
      bw_nxt = reg_wdata[`PLLCC_BW_HI:`PLLCC_BW_LO];
      cp_nxt = reg_wdata[`PLLCC_CP_HI:`PLLCC_CP_LO];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bw_r <= `PLLCC_RST_BW;
      cp_r <= `PLLCC_RST_CP;
    end else begin
      bw_r <= bw_nxt;
      cp_r <= cp_nxt;
    end
  end

  // dividers
  logic [1:0] cdiv_r, cdiv_nxt;
  logic xctl_r, xctl_nxt;
  logic [1:0] odiv_r, odiv_nxt;
  logic [1:0] ldiv_r, ldiv_nxt;

  // no guard on the controller divider: software keeps its clock legal
  always_comb begin
    cdiv_nxt = cdiv_r;
    xctl_nxt = xctl_r;
    odiv_nxt = odiv_r;
    ldiv_nxt = ldiv_r;
    if (wr_divct) begin
      cdiv_nxt = reg_wdata[`PLLCC_CDIV_HI:`PLLCC_CDIV_LO];
      xctl_nxt = reg_wdata[`PLLCC_BIT_XCTL_EN];
      odiv_nxt = reg_wdata[`PLLCC_ODIV_HI:`PLLCC_ODIV_LO];
      ldiv_nxt = reg_wdata[`PLLCC_LDIV_HI:`PLLCC_LDIV_LO];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cdiv_r <= `PLLCC_RST_CDIV;
      xctl_r <= `PLLCC_RST_XCTL_EN;
      odiv_r <= `PLLCC_RST_ODIV;
      ldiv_r <= `PLLCC_RST_LDIV;
    end else begin
      cdiv_r <= cdiv_nxt;
      xctl_r <= xctl_nxt;
      odiv_r <= odiv_nxt;
      ldiv_r <= ldiv_nxt;
    end
  end

  // ratios lag their code by one cycle
  pllcc_ratio #(
    .SHIFT(`PLLCC_SHIFT_CDIV),
    .CAP(`PLLCC_CAP_NONE)
  ) u_cdiv (
    .sys_clk(sys_clk),
    .rst(rst),
    .code(cdiv_r),
    .ratio(controller_clock_ratio)
  );

  pllcc_ratio #(
    .SHIFT(`PLLCC_SHIFT_ODIV),
    .CAP(`PLLCC_CAP_ODIV)
  ) u_odiv (
    .sys_clk(sys_clk),
    .rst(rst),
    .code(odiv_r),
    .ratio(oscillator_output_ratio)
  );

  pllcc_ratio #(
    .SHIFT(`PLLCC_SHIFT_LDIV),
    .CAP(`PLLCC_CAP_NONE)
  ) u_ldiv (
    .sys_clk(sys_clk),
    .rst(rst),
    .code(ldiv_r),
    .ratio(loop_ratio)
  );

  // event flags
  logic sust_flag;
  logic samp_flag;

  pllcc_flag #(
    .AUTO_CLR(1'b1),
    .CLR_PAIRS(CLR_PAIRS)
  ) u_sust (
    .sys_clk(sys_clk),
    .rst(rst),
    .set_evt(sustained_mismatch),
    .clr_w1c(wr_flags && reg_wdata[`PLLCC_BIT_SUST_FAIL]),
    .valid_pair(valid_pair),
    .flag(sust_flag)
  );

  pllcc_flag #(
    .AUTO_CLR(1'b0),
    .CLR_PAIRS(CLR_PAIRS)
  ) u_samp (
    .sys_clk(sys_clk),
    .rst(rst),
    .set_evt(sample_mismatch),
    .clr_w1c(wr_flags && reg_wdata[`PLLCC_BIT_SAMP_FAIL]),
    .valid_pair(1'b0),
    .flag(samp_flag)
  );

  // read path, one cycle after the strobe; unmapped reads return zero
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;

  always_comb begin
    rdata_nxt = '0;
    rvalid_nxt = reg_rd;
    if (reg_rd) begin
      if (hit(reg_addr, `PLLCC_OFS_FLAGS)) begin
        rdata_nxt[`PLLCC_BIT_SUST_FAIL] = sust_flag;
        rdata_nxt[`PLLCC_BIT_SAMP_FAIL] = samp_flag;
      end else if (hit(reg_addr, `PLLCC_OFS_RXCTL)) begin
        rdata_nxt[`PLLCC_BIT_CONV_DUTY] = conv_duty_r;
        rdata_nxt[`PLLCC_BIT_REF_DUTY] = ref_duty_r;
        rdata_nxt[`PLLCC_BIT_CONV_CROSS] = conv_cross_r;
        rdata_nxt[`PLLCC_BIT_REF_CROSS] = ref_cross_r;
      end else if (hit(reg_addr, `PLLCC_OFS_PLLEN)) begin
        rdata_nxt[`PLLCC_BIT_PLL_EN] = pll_en_r;
        rdata_nxt[`PLLCC_BIT_MAN_EN] = man_en_r;
        rdata_nxt[`PLLCC_BAND_HI:`PLLCC_BAND_LO] = band_r;
      end else if (hit(reg_addr, `PLLCC_OFS_LOOPF)) begin
        rdata_nxt[`PLLCC_BW_HI:`PLLCC_BW_LO] = bw_r;
        rdata_nxt[`PLLCC_CP_HI:`PLLCC_CP_LO] = cp_r;
      end else if (hit(reg_addr, `PLLCC_OFS_DIVCT)) begin
        rdata_nxt[`PLLCC_CDIV_HI:`PLLCC_CDIV_LO] = cdiv_r;
        rdata_nxt[`PLLCC_BIT_XCTL_EN] = xctl_r;
        rdata_nxt[`PLLCC_ODIV_HI:`PLLCC_ODIV_LO] = odiv_r;
        rdata_nxt[`PLLCC_LDIV_HI:`PLLCC_LDIV_LO] = ldiv_r;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign sustained_fail_flag = sust_flag;
  assign sample_fail_flag = samp_flag;
  assign conv_duty_corr_en = conv_duty_r;
  assign ref_duty_corr_en = ref_duty_r;
  assign conv_cross_corr_en = conv_cross_r;
  assign ref_cross_corr_en = ref_cross_r;
  assign pll_en = pll_en_r;
  assign manual_band_en = man_en_r;
  assign manual_oscillator_band = band_r;
  assign loop_bandwidth = bw_r;
  assign charge_pump_current = cp_r;
  assign controller_clock_divider = cdiv_r;
  assign cross_ctl_en = xctl_r;
  assign oscillator_output_divider = odiv_r;
  assign loop_divider = ldiv_r;

endmodule : pllcc_top

// *** include/pllcc_map.svh ***
// register offsets, field positions, reset values and counts of the block
`ifndef PLLCC_MAP_SVH
`define PLLCC_MAP_SVH

`define PLLCC_ADDR_W 8
`define PLLCC_DATA_W 8

`define PLLCC_OFS_FLAGS 8'h07
`define PLLCC_OFS_RXCTL 8'h08
`define PLLCC_OFS_PLLEN 8'h0A
`define PLLCC_OFS_LOOPF 8'h0C
`define PLLCC_OFS_DIVCT 8'h0D

`define PLLCC_BIT_SUST_FAIL 3
`define PLLCC_BIT_SAMP_FAIL 2

`define PLLCC_BIT_CONV_DUTY 7
`define PLLCC_BIT_REF_DUTY 6
`define PLLCC_BIT_CONV_CROSS 5
`define PLLCC_BIT_REF_CROSS 4
`define PLLCC_RST_CONV_DUTY 1'h0
`define PLLCC_RST_REF_DUTY 1'h0
`define PLLCC_RST_CONV_CROSS 1'h1
`define PLLCC_RST_REF_CROSS 1'h1

`define PLLCC_BIT_PLL_EN 7
`define PLLCC_BIT_MAN_EN 6
`define PLLCC_BAND_HI 5
`define PLLCC_BAND_LO 0
`define PLLCC_RST_PLL_EN 1'h0
`define PLLCC_RST_MAN_EN 1'h1
`define PLLCC_RST_BAND 6'h00

`define PLLCC_BW_HI 7
`define PLLCC_BW_LO 6
`define PLLCC_CP_HI 4
`define PLLCC_CP_LO 0
`define PLLCC_RST_BW 2'h3
`define PLLCC_RST_CP 5'h11

`define PLLCC_CDIV_HI 7
`define PLLCC_CDIV_LO 6
`define PLLCC_BIT_XCTL_EN 4
`define PLLCC_ODIV_HI 3
`define PLLCC_ODIV_LO 2
`define PLLCC_LDIV_HI 1
`define PLLCC_LDIV_LO 0
`define PLLCC_RST_CDIV 2'h3
`define PLLCC_RST_XCTL_EN 1'h1
`define PLLCC_RST_ODIV 2'h2
`define PLLCC_RST_LDIV 2'h1

// ratio = 2 ** (code + shift), optionally capped
`define PLLCC_SHIFT_CDIV 3'h1
`define PLLCC_SHIFT_ODIV 3'h0
`define PLLCC_SHIFT_LDIV 3'h1
`define PLLCC_CAP_NONE 5'h10
`define PLLCC_CAP_ODIV 5'h04

`define PLLCC_AUTO_CLR_PAIRS 8

`endif

// *** include/pllcc_pkg.sv ***
// types and shared functions of the clock configuration block
package pllcc_pkg;

  typedef enum logic [1:0] {
    PLLCC_FLAG_IDLE = 2'h1,
    PLLCC_FLAG_HELD = 2'h2
  } pllcc_flag_st_t;

  // power-of-two divide ratio from a 2-bit code, with an upper cap
  function automatic logic [4:0] pllcc_ratio_f(
    input logic [1:0] code,
    input logic [2:0] shift,
    input logic [4:0] cap
  );
    logic [4:0] r;
    r = 5'h01 << ({1'b0, code} + shift);
    if (r > cap) begin
      r = cap;
    end
    return r;
  endfunction : pllcc_ratio_f

endpackage : pllcc_pkg

// *** src/pllcc_flag.sv ***
// latched event flag with write-one clear and optional self clear
`timescale 1ns/1ps
`include "pllcc_map.svh"

module pllcc_flag
  import pllcc_pkg::*;
#(
  parameter bit AUTO_CLR = 1'b0,
  parameter int CLR_PAIRS = `PLLCC_AUTO_CLR_PAIRS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic set_evt,
  input wire logic clr_w1c,
  input wire logic valid_pair,
  output logic flag
);

  localparam int CW = $clog2(CLR_PAIRS + 1);

  if (CLR_PAIRS < 1) begin : g_chk
    $error("pllcc_flag: CLR_PAIRS must be at least 1");
  end

  pllcc_flag_st_t st_r;
  pllcc_flag_st_t st_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  // flag kept in its own flop so the top's flag outputs come from a flop
  logic flag_r;
  logic flag_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      PLLCC_FLAG_IDLE: begin
        cnt_nxt = '0;
        if (set_evt) begin
          st_nxt = PLLCC_FLAG_HELD;
        end
      end
      PLLCC_FLAG_HELD: begin
        // a new mismatch wins over a clear in the same cycle
        if (set_evt) begin
          cnt_nxt = '0;
        end else if (clr_w1c) begin
          st_nxt = PLLCC_FLAG_IDLE;
          cnt_nxt = '0;
        end else if (AUTO_CLR && valid_pair) begin
          if (cnt_r == CW'(CLR_PAIRS - 1)) begin
            st_nxt = PLLCC_FLAG_IDLE;
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r + CW'(1);
          end
        end
      end
      default: begin
        st_nxt = PLLCC_FLAG_IDLE;
        cnt_nxt = '0;
      end
    endcase
    flag_nxt = (st_nxt == PLLCC_FLAG_HELD);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= PLLCC_FLAG_IDLE;
      cnt_r <= '0;
      flag_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

endmodule : pllcc_flag

// *** src/pllcc_ratio.sv ***
// registered decode of a divider code into its ratio
`timescale 1ns/1ps
`include "pllcc_map.svh"

module pllcc_ratio
  import pllcc_pkg::*;
#(
  parameter logic [2:0] SHIFT = `PLLCC_SHIFT_LDIV,
  parameter logic [4:0] CAP = `PLLCC_CAP_NONE
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] code,
  output logic [4:0] ratio
);

  logic [4:0] ratio_r;
  logic [4:0] ratio_nxt;

  always_comb begin
    ratio_nxt = pllcc_ratio_f(code, SHIFT, CAP);
  end

  // reads zero while in reset; decoded from the first edge after release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ratio_r <= 5'h00;
    end else begin
      ratio_r <= ratio_nxt;
    end
  end

  assign ratio = ratio_r;

endmodule : pllcc_ratio

// *** test/pllcc_top_asserts.sv ***
// port-level assertions for the clock configuration block
`timescale 1ns/1ps
`include "pllcc_map.svh"

module pllcc_top_asserts
  import pllcc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8,
  parameter int CLR_PAIRS = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic sustained_mismatch,
  input wire logic sample_mismatch,
  input wire logic sustained_fail_flag,
  input wire logic sample_fail_flag,
  input wire logic conv_duty_corr_en,
  input wire logic ref_duty_corr_en,
  input wire logic conv_cross_corr_en,
  input wire logic ref_cross_corr_en,
  input wire logic pll_en,
  input wire logic manual_band_en,
  input wire logic cross_ctl_en,
  input wire logic [1:0] controller_clock_divider,
  input wire logic [1:0] oscillator_output_divider,
  input wire logic [1:0] loop_divider,
  input wire logic [4:0] controller_clock_ratio,
  input wire logic [4:0] oscillator_output_ratio,
  input wire logic [4:0] loop_ratio
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic wr7;
  logic [DATA_W-1:0] wd_q;
  assign wr7 = reg_wr && (reg_addr == `PLLCC_OFS_FLAGS);
  // write data one edge back, so fields can be tied to what was written
  always_ff @(posedge sys_clk) begin
    wd_q <= reg_wdata;
  end

  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe got no answer");
  a_rdata_idle: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer");
  a_samp_set: assert property (sample_mismatch |=> sample_fail_flag)
    else $error("sample flag not set");
  a_samp_hold: assert property (sample_fail_flag &&
    !(wr7 && reg_wdata[2]) |=> sample_fail_flag)
    else $error("sample flag dropped without clear");
  a_samp_w1c: assert property (wr7 && reg_wdata[2] &&
    !sample_mismatch |=> !sample_fail_flag)
    else $error("sample flag not cleared by write one");
  a_sust_set: assert property (sustained_mismatch |=> sustained_fail_flag)
    else $error("sustained flag not set");
  a_rxctl_write: assert property (reg_wr && reg_addr == 8'h08 |=>
    {conv_duty_corr_en, ref_duty_corr_en, conv_cross_corr_en,
     ref_cross_corr_en} == wd_q[7:4])
    else $error("receiver enables differ from write");
  a_pllen_write: assert property (reg_wr && reg_addr == 8'h0A |=>
    {pll_en, manual_band_en} == wd_q[7:6])
    else $error("pll enables differ from write");
  a_divct_write: assert property (reg_wr && reg_addr == 8'h0D |=>
    {controller_clock_divider, cross_ctl_en, oscillator_output_divider,
     loop_divider} == {wd_q[7:6], wd_q[4:0]})
    else $error("divider fields differ from write");
  a_loop_ratio: assert property (!$past(rst) |->
    loop_ratio == (5'h02 << $past(loop_divider)))
    else $error("loop ratio wrong");
  a_ctl_ratio: assert property (!$past(rst) |->
    controller_clock_ratio == (5'h02 << $past(controller_clock_divider)))
    else $error("controller ratio wrong");
  a_osc_ratio: assert property (!$past(rst) |->
    oscillator_output_ratio == (($past(oscillator_output_divider) >= 2'h2)
    ? 5'h04 : (5'h01 << $past(oscillator_output_divider))))
    else $error("oscillator ratio wrong");
endmodule : pllcc_top_asserts

bind pllcc_top pllcc_top_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
  .CLR_PAIRS(CLR_PAIRS)) u_chk (.sys_clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .sustained_mismatch,
  .sample_mismatch, .sustained_fail_flag, .sample_fail_flag,
  .conv_duty_corr_en, .ref_duty_corr_en, .conv_cross_corr_en,
  .ref_cross_corr_en, .pll_en, .manual_band_en, .cross_ctl_en,
  .controller_clock_divider, .oscillator_output_divider, .loop_divider,
  .controller_clock_ratio, .oscillator_output_ratio, .loop_ratio);

// *** test/pllcc_top_tb_top.sv ***
// self-checking bench for the clock configuration block
`timescale 1ns/1ps

module pllcc_top_tb_top
  import pllcc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst, reg_wr, reg_rd, reg_rvalid, valid_pair;
  logic sustained_mismatch, sample_mismatch;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic sustained_fail_flag, sample_fail_flag, pll_en, manual_band_en;
  logic conv_duty_corr_en, ref_duty_corr_en, cross_ctl_en;
  logic conv_cross_corr_en, ref_cross_corr_en;
  logic [5:0] manual_oscillator_band;
  logic [1:0] loop_bandwidth, controller_clock_divider;
  logic [1:0] oscillator_output_divider, loop_divider;
  logic [4:0] charge_pump_current, controller_clock_ratio;
  logic [4:0] oscillator_output_ratio, loop_ratio;
  int n_mismatch = 0;
  int checked = 0;

  always #2.5 sys_clk = ~sys_clk;

  pllcc_top #(.CLR_PAIRS(8)) dut (.sys_clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .sustained_mismatch,
    .sample_mismatch, .valid_pair, .sustained_fail_flag, .sample_fail_flag,
    .conv_duty_corr_en, .ref_duty_corr_en, .conv_cross_corr_en,
    .ref_cross_corr_en, .pll_en, .manual_band_en, .manual_oscillator_band,
    .loop_bandwidth, .charge_pump_current, .controller_clock_divider,
    .cross_ctl_en, .oscillator_output_divider, .loop_divider,
    .controller_clock_ratio, .oscillator_output_ratio, .loop_ratio);

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int i;
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    i = 0;
    while (reg_rvalid !== 1'b1 && i < 4) begin
      @(negedge sys_clk);
      i++;
    end
    if (reg_rvalid !== 1'b1) begin
      n_mismatch++;
      $display("BAD rvalid expected 1 seen 0");
      final_report();
    end else begin
      chk($sformatf("reg %h", a), e, reg_rdata);
    end
  endtask : rd

  // k: 0 sustained mismatch, 1 sample mismatch, else one valid pair
  task automatic ev(input int k);
    @(posedge sys_clk);
    if (k == 0) sustained_mismatch <= 1'b1;
    else if (k == 1) sample_mismatch <= 1'b1;
    else valid_pair <= 1'b1;
    @(posedge sys_clk);
    sustained_mismatch <= 1'b0;
    sample_mismatch <= 1'b0;
    valid_pair <= 1'b0;
  endtask : ev

  task automatic t_reset();
    rd(8'h08, 8'h30);
    rd(8'h0A, 8'h40);
    rd(8'h0C, 8'hD1);
    rd(8'h0D, 8'hD9);
    rd(8'h07, 8'h00);
    chk("ctl ratio", 8'h10, {3'h0, controller_clock_ratio});
    chk("osc ratio", 8'h04, {3'h0, oscillator_output_ratio});
    chk("loop ratio", 8'h04, {3'h0, loop_ratio});
    $display("test reset values done");
  endtask : t_reset

  task automatic t_fields();
    wr(8'h08, 8'h5F);
    rd(8'h08, 8'h50);
    chk("rx en", 8'h05, {4'h0, conv_duty_corr_en, ref_duty_corr_en,
      conv_cross_corr_en, ref_cross_corr_en});
    wr(8'h0A, 8'hA5);
    rd(8'h0A, 8'hA5);
    chk("pll", 8'hA5, {pll_en, manual_band_en, manual_oscillator_band});
    wr(8'h0C, 8'h7F);
    rd(8'h0C, 8'h5F);
    chk("loop", 8'h5F, {loop_bandwidth, 1'b0, charge_pump_current});
    wr(8'h0D, 8'h6E);
    rd(8'h0D, 8'h4E);
    chk("div", 8'h4E, {controller_clock_divider, 1'b0, cross_ctl_en,
      oscillator_output_divider, loop_divider});
    // unmapped offset must neither answer data nor disturb neighbours
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'h00);
    rd(8'h08, 8'h50);
    $display("test field readback done");
  endtask : t_fields

  task automatic t_codes();
    logic [1:0] c;
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      // software side: codes only ever chosen to keep the controller clock legal
      wr(8'h0D, {c, 2'h1, c, c});
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk("ctl ratio", 8'(5'h02 << c), {3'h0, controller_clock_ratio});
      chk("osc ratio", (c >= 2'h2) ? 8'h04 : 8'(5'h01 << c),
        {3'h0, oscillator_output_ratio});
      chk("loop ratio", 8'(5'h02 << c), {3'h0, loop_ratio});
    end
    $display("test divider codes done");
  endtask : t_codes

  task automatic t_sample();
    ev(1);
    @(negedge sys_clk);
    chk("samp flag", 8'h01, {7'h0, sample_fail_flag});
    repeat (9) ev(2);
    @(negedge sys_clk);
    chk("samp held", 8'h01, {7'h0, sample_fail_flag});
    wr(8'h07, 8'h08);
    rd(8'h07, 8'h04);
    wr(8'h07, 8'h04);
    @(negedge sys_clk);
    chk("samp clr", 8'h00, {7'h0, sample_fail_flag});
    $display("test sample flag done");
  endtask : t_sample

  task automatic t_sust();
    ev(0);
    repeat (5) ev(2);
    ev(0);
    repeat (7) ev(2);
    @(negedge sys_clk);
    chk("sust held", 8'h01, {7'h0, sustained_fail_flag});
    rd(8'h07, 8'h08);
    ev(2);
    @(negedge sys_clk);
    chk("sust auto", 8'h00, {7'h0, sustained_fail_flag});
    ev(0);
    ev(1);
    wr(8'h07, 8'h08);
    @(negedge sys_clk);
    chk("sust clr", 8'h00, {7'h0, sustained_fail_flag});
    chk("samp kept", 8'h01, {7'h0, sample_fail_flag});
    $display("test sustained flag done");
  endtask : t_sust

  // second reset in mid-run: flags drop, register 0x0D fields and the loop ratio return
  task automatic t_rerun();
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("ratio in rst", 8'h00, {3'h0, loop_ratio});
    chk("samp in rst", 8'h00, {7'h0, sample_fail_flag});
    @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h07, 8'h00);
    rd(8'h0D, 8'hD9);
    chk("loop ratio", 8'h04, {3'h0, loop_ratio});
    $display("test reset rerun done");
  endtask : t_rerun

  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sustained_mismatch = 1'b0;
    sample_mismatch = 1'b0;
    valid_pair = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_codes();
    t_sample();
    t_sust();
    t_rerun();
    final_report();
  end
endmodule : pllcc_top_tb_top
